// ===== verilog/hsc_defs.vh
// constants for the high-speed pulse counter block
`ifndef HSC_DEFS_VH
`define HSC_DEFS_VH
`define HSC_SEL_CTR0       12'h000
`define HSC_FN_START_CMP   12'h000
`define HSC_FN_STOP_CMP    12'h001
`define HSC_FN_LOAD_PV     12'h002
`define HSC_SETUP_INC_SW   16'h0114
`define HSC_SETUP_UPDN_SW  16'h0104
`define HSC_PV_OVERFLOW    32'h0FFFFFFF
`define HSC_PV_UNDERFLOW   32'hFFFFFFFF
`define HSC_UPDN_MAX       17'sh07FFF
`define HSC_UPDN_MIN       -17'sh07FFF
`define HSC_INC_MAX        17'sh0FFFF
`define HSC_MAX_ENTRIES    8
`define HSC_ENTRY_IDX_W    3
`define HSC_ROUTINE_W      16
`endif

// ===== verilog/hsc_counter.v
// high-speed pulse counter with value load, saturation and target matching
`timescale 1ns/1ps
`default_nettype none
`include "hsc_defs.vh"
module hsc_counter (
   input  wire        ref_clk,       // 10 MHz clock
   input  wire        rst_n,         // synchronous reset, active low
   input  wire [15:0] counter_setup_word, // setup, sampled at start
   input  wire        start_run,     // pulse: program execution begins
   input  wire        pulse_a,       // count pulse or encoder A pin
   input  wire        pulse_b,       // encoder B pin
   input  wire        soft_reset,    // counter reset bit, level
   input  wire        op_valid,      // counter_control_op request pulse
   input  wire [11:0] op_sel,        // counter selector
   input  wire [11:0] op_fn,         // function code
   input  wire [15:0] op_word_lo,    // rightmost four digits
   input  wire [15:0] op_word_hi,    // leftmost four digits
   input  wire        tbl_we,        // compare_table_load_op entry write
   input  wire [2:0]  tbl_idx,       // entry index
   input  wire [15:0] tbl_tgt_lo,    // target rightmost digits
   input  wire [15:0] tbl_tgt_hi,    // target leftmost digits
   input  wire [15:0] tbl_routine,   // routine number
   input  wire [3:0]  tbl_count,     // number of conditions
   input  wire        tbl_set,       // latch count
   input  wire        tbl_start,     // begin matching after table set
   output reg  [15:0] present_count_lo, // rightmost four digits
   output reg  [15:0] present_count_hi, // leftmost four digits
   output reg         ovf_status,    // overflow or underflow held
   output reg         enabled,       // counter in use
   output reg         cmp_active,    // matching running
   output reg         irq_call,      // pulse: routine to call
   output reg  [15:0] irq_routine,   // routine number with irq_call
   output reg         op_refused     // pulse: request refused
);
   reg [1:0]         a_sync;        // pin a synchroniser
   reg [1:0]         b_sync;        // pin b synchroniser
   reg [1:0]         r_sync;        // reset bit synchroniser
   reg               a_q;           // pin a, previous synced level
   reg               b_q;           // pin b, previous synced level
   reg               rst_q;         // reset bit, edge-aligned stage
   reg               updn;          // up/down mode latched at start
   reg signed [16:0] cnt;           // binary count
   reg [15:0]        tgt_lo [0:7];  // target rightmost digits
   reg [15:0]        tgt_hi [0:7];  // target leftmost digits
   reg [15:0]        rtn [0:7];     // routine numbers
   reg [3:0]         n_ent;         // entries in use
   reg [2:0]         ptr;           // entry being matched
   reg signed [16:0] step;          // -1, 0 or +1 this cycle
   reg signed [17:0] next_cnt;      // count after this step
   reg [31:0]        next_view;     // bcd view shown next edge
   reg               over_hi;       // next count above the range
   reg               over_lo;       // next count below the range
   integer           k;

   // range limits widened to the step arithmetic, kept signed so
   // that a negative next count never compares as a huge value
   localparam signed [17:0] UPDN_MAX = `HSC_UPDN_MAX;
   localparam signed [17:0] UPDN_MIN = `HSC_UPDN_MIN;
   localparam signed [17:0] INC_MAX  = `HSC_INC_MAX;
   localparam signed [17:0] INC_MIN  = 18'sh0;

   // bcd of magnitude 0..65535, F leading digit for negatives
   function [31:0] to_bcd;
      input signed [16:0] v;
      reg [16:0] m;
      reg [16:0] q;
      reg [31:0] r;
      integer    i;
      begin
         m = v[16] ? -v : v;
         r = 32'h0;
         for (i = 0; i < 8; i = i + 1) begin
            q = m % 17'd10;
            r = {q[3:0], r[31:4]};
            m = m / 17'd10;
         end
         if (v[16])
            r[31:28] = 4'hF;
         to_bcd = r;
      end
   endfunction

   // bcd word pair to signed count, F leading digit negative
   function signed [16:0] from_bcd;
      input [31:0] b;
      reg [16:0] m;
      begin
         m = b[19:16] * 17'd10000 + b[15:12] * 17'd1000
           + b[11:8] * 17'd100 + b[7:4] * 17'd10 + {13'h0, b[3:0]};
         from_bcd = (b[31:28] == 4'hF) ? -m : m;
      end
   endfunction

   // two-stage synchronisers for pins; the edge stages idle low like
   // the pins, so no false edge follows reset
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         a_sync <= 2'h0;
         b_sync <= 2'h0;
         r_sync <= 2'h0;
         a_q <= 1'b0;
         b_q <= 1'b0;
         rst_q <= 1'b0;
      end else begin
         a_sync <= {a_sync[0], pulse_a};
         b_sync <= {b_sync[0], pulse_b};
         r_sync <= {r_sync[0], soft_reset};
         a_q <= a_sync[1];
         b_q <= b_sync[1];
         rst_q <= r_sync[1];
      end
   end

   // count step: rising a in inc mode, 4x quadrature in up/down mode;
   // forward order is a up, b up, a down, b down
   always @* begin
      step = 17'sh0;
      if (!updn) begin
         if (a_sync[1] && !a_q)
            step = 17'sh1;
      end else if (a_sync[1] != a_q) begin
         step = (a_sync[1] ^ b_sync[1]) ? 17'sh1 : -17'sh1;
      end else if (b_sync[1] != b_q) begin
         step = (a_sync[1] ^ b_sync[1]) ? -17'sh1 : 17'sh1;
      end
      next_cnt = {cnt[16], cnt} + {step[16], step};
      over_hi = next_cnt > (updn ? UPDN_MAX : INC_MAX);
      over_lo = next_cnt < (updn ? UPDN_MIN : INC_MIN);
   end

   // bcd view of the count, sentinel words while saturated
   always @* begin
      next_view = to_bcd(cnt);
      if (ovf_status)
         next_view = cnt[16] ? `HSC_PV_UNDERFLOW
                             : `HSC_PV_OVERFLOW;
   end

   // counter, load, saturation and matching
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         cnt <= 17'sh0;
         ovf_status <= 1'b0;
         enabled <= 1'b0;
         updn <= 1'b0;
         cmp_active <= 1'b0;
         irq_call <= 1'b0;
         irq_routine <= 16'h0;
         op_refused <= 1'b0;
         n_ent <= 4'h0;
         ptr <= 3'h0;
         present_count_lo <= 16'h0;
         present_count_hi <= 16'h0;
         for (k = 0; k < 8; k = k + 1) begin
            tgt_lo[k] <= 16'h0;
            tgt_hi[k] <= 16'h0;
            rtn[k] <= 16'h0;
         end
      end else begin
         irq_call <= 1'b0;
         op_refused <= 1'b0;
         if (start_run) begin
            enabled <= (counter_setup_word == `HSC_SETUP_INC_SW) ||
                       (counter_setup_word == `HSC_SETUP_UPDN_SW);
            updn <= (counter_setup_word != `HSC_SETUP_INC_SW);
            cnt <= 17'sh0;
            ovf_status <= 1'b0;
         end else if (rst_q) begin
            cnt <= 17'sh0;
            ovf_status <= 1'b0;
         end else if (op_valid && op_sel == `HSC_SEL_CTR0) begin
            if (ovf_status)
               op_refused <= 1'b1;
            else if (op_fn == `HSC_FN_LOAD_PV) begin
               cnt <= from_bcd({op_word_hi, op_word_lo});
               ptr <= 3'h0;
            end else if (op_fn == `HSC_FN_START_CMP)
               cmp_active <= 1'b1;
            else if (op_fn == `HSC_FN_STOP_CMP)
               cmp_active <= 1'b0;
         end else if (enabled && !ovf_status) begin
            // leaving the range freezes the count at its last value
            if (over_hi || over_lo)
               ovf_status <= 1'b1;
            else
               cnt <= next_cnt[16:0];
            // target match, never on the step that saturates
            if (cmp_active && n_ent != 4'h0 && step != 17'sh0 &&
                !over_hi && !over_lo &&
                to_bcd(next_cnt[16:0]) == {tgt_hi[ptr], tgt_lo[ptr]}) begin
               irq_call <= 1'b1;
               irq_routine <= rtn[ptr];
               ptr <= ({1'b0, ptr} + 4'h1 >= n_ent) ? 3'h0 : ptr + 3'h1;
            end
         end
         // table entry writes kept through saturation
         if (tbl_we) begin
            tgt_lo[tbl_idx] <= tbl_tgt_lo;
            tgt_hi[tbl_idx] <= tbl_tgt_hi;
            rtn[tbl_idx] <= tbl_routine;
         end
         if (tbl_set) begin
            n_ent <= (tbl_count > 4'd8) ? 4'd8 : tbl_count;
            ptr <= 3'h0;
            if (tbl_start && ovf_status)
               op_refused <= 1'b1;
            else
               cmp_active <= tbl_start;
         end
         // both words from one value on the same edge, never torn
         {present_count_hi, present_count_lo} <= next_view;
      end
   end
endmodule
`default_nettype wire

// ===== testbench/hsc_counter_properties.sv
// port assertions for the pulse counter
`timescale 1ns/1ps
`default_nettype none
module hsc_props (
   input wire logic        ref_clk, rst_n, start_run, soft_reset, op_valid,
   input wire logic        ovf_status, enabled, cmp_active, irq_call,
   input wire logic        op_refused,
   input wire logic [11:0] op_sel, op_fn,
   input wire logic [15:0] counter_setup_word, op_word_lo, op_word_hi,
   input wire logic [15:0] present_count_lo, present_count_hi
);
   wire logic [31:0] pc = {present_count_hi, present_count_lo};
   wire logic req = op_valid && op_sel == 12'h000 && !start_run && !soft_reset;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   AST_LOAD: assert property (req && op_fn == 12'h002
      && !ovf_status && enabled |-> ##2 present_count_lo ==
      $past(op_word_lo, 2) && present_count_hi == $past(op_word_hi, 2))
      else $error("load not seen in both words");
   AST_REFUSE: assert property (req && ovf_status |=> op_refused)
      else $error("request taken in overflow");
   AST_HOLD: assert property (ovf_status && $past(ovf_status, 2)
      |-> pc == 32'h0FFFFFFF || pc == 32'hFFFFFFFF)
      else $error("saturation value not held");
   AST_NOIRQ: assert property (ovf_status && $past(ovf_status)
      |-> !irq_call) else $error("routine called in overflow");
   AST_CLR: assert property (soft_reset [*6] |-> pc == 32'h0
      && !ovf_status) else $error("reset did not clear count");
   AST_RANGE: assert property (!ovf_status && !$past(ovf_status, 2)
      |-> (present_count_hi[15:12] == 4'hF ? present_count_hi <= 16'hF003
      : present_count_hi <= 16'h0006)) else $error("count out of range");
   AST_IRQ: assert property (irq_call |-> cmp_active && enabled)
      else $error("routine call while matching idle");
   AST_SETUP: assert property (start_run
      && counter_setup_word == 16'h0114 |-> ##[1:2] enabled)
      else $error("setup did not enable counter");
   COV_IRQ: cover property (irq_call);
   COV_OVF: cover property ($rose(ovf_status));
   COV_REF: cover property (op_refused);
   COV_UNDER: cover property (ovf_status && present_count_hi == 16'hFFFF);
endmodule
bind hsc_counter hsc_props u_props (.ref_clk, .rst_n, .start_run,
   .soft_reset, .op_valid, .ovf_status, .enabled, .cmp_active, .irq_call,
   .op_refused, .op_sel, .op_fn, .counter_setup_word, .op_word_lo,
   .op_word_hi, .present_count_lo, .present_count_hi);
`default_nettype wire

// ===== testbench/hsc_pulse_src.sv
// single-phase pulse or two-phase encoder source on the counting pins
`timescale 1ns/1ps
`default_nettype none
module hsc_pulse_src (
   input  wire logic       ref_clk, // bench clock
   input  wire logic       go,      // pulse: start a burst
   input  wire logic [7:0] n,       // pulses in burst
   input  wire logic [2:0] half,    // half period less one cycle, sets the pace
   input  wire logic       quad,    // two-phase encoder mode
   input  wire logic       dn,      // encoder runs in reverse
   output wire logic       pulse_a, // count pin or phase a, idles low in single mode
   output wire logic       pulse_b, // phase b, low in single mode
   output wire logic       busy     // burst running
);
   logic [7:0] left = 8'h00;
   logic [2:0] ph = 3'h0;
   logic [1:0] st = 2'h0; // encoder phase: ab 00 10 11 01 forward
   assign pulse_a = quad ? (st == 2'h1 || st == 2'h2) : st[0];
   assign pulse_b = quad && st[1];
   assign busy = left != 8'h00;
   // single: toggle a, count on its fall; encoder: each edge counts
   always @(posedge ref_clk) begin
      ph <= (ph == half) ? 3'h0 : ph + 3'h1;
      if (go) begin
         left <= n;
         ph <= 3'h0;
      end else if (busy && ph == half) begin
         if (!quad)
            st <= {1'b0, !st[0]};
         else
            st <= dn ? st - 2'h1 : st + 2'h1;
         if (quad || st[0])
            left <= left - 8'h01;
      end
   end
endmodule
`default_nettype wire

// ===== testbench/hsc_counter_tb.sv
// self-checking bench for the pulse counter
`timescale 1ns/1ps
`default_nettype none
`include "hsc_defs.vh"
module hsc_counter_tb;
   logic ref_clk, rst_n, start_run, soft_reset, op_valid, tbl_we, tbl_set;
   logic tbl_start, go, pa, pb, busy, ovf, en, cmp, irq, refused;
   logic quad, dn;
   logic [11:0] op_sel, op_fn;
   logic [15:0] setup, wlo, whi, tlo, thi, rout, plo, phi, irq_r, lo;
   logic [2:0] idx, half;
   logic [3:0] tcount;
   logic [7:0] n;
   logic [31:0] exp_q[$];
   int num_errors, total_checks, cyc;
   hsc_counter dut (.ref_clk, .rst_n, .counter_setup_word(setup), .start_run,
      .pulse_a(pa), .pulse_b(pb), .soft_reset, .op_valid, .op_sel, .op_fn,
      .op_word_lo(wlo), .op_word_hi(whi), .tbl_we, .tbl_idx(idx),
      .tbl_tgt_lo(tlo), .tbl_tgt_hi(thi), .tbl_routine(rout),
      .tbl_count(tcount), .tbl_set, .tbl_start, .present_count_lo(plo),
      .present_count_hi(phi), .ovf_status(ovf), .enabled(en),
      .cmp_active(cmp), .irq_call(irq), .irq_routine(irq_r),
      .op_refused(refused));
   hsc_pulse_src src (.ref_clk, .go, .n, .half, .quad, .dn, .pulse_a(pa),
      .pulse_b(pb), .busy);
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      if (num_errors == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask
   task automatic op(input logic [11:0] f, input logic [31:0] v);
      op_fn = f; {whi, wlo} = v; op_valid = 1; tick(1); op_valid = 0; tick(3);
   endtask
   task automatic pulses(input logic [7:0] k);
      n = k; go = 1; tick(1); go = 0;
      for (int i = 0; i < 400 && busy; i++) tick(1);
      tick(6);
   endtask
   task automatic entry(input logic [2:0] i, input logic [15:0] t, r);
      idx = i; tlo = t; rout = r; tbl_we = 1; tick(1); tbl_we = 0;
   endtask
   // clock, 100 ns period
   initial begin
      ref_clk = 0;
      forever #50 ref_clk = !ref_clk;
   end
   // scoreboard: each routine call or refusal takes the oldest note
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin num_errors++; stop_test(); end
      if (irq) check({16'h0, irq_r}, exp_q.pop_front());
      if (refused) check(32'hFFFF, exp_q.pop_front());
   end
   initial begin
      {rst_n, start_run, soft_reset, op_valid, tbl_we, tbl_set, go} = '0;
      {tbl_start, op_fn, wlo, whi, tlo, thi, rout, idx, tcount, n} = '0;
      op_sel = `HSC_SEL_CTR0; setup = `HSC_SETUP_INC_SW; half = 3'h2;
      num_errors = 0; total_checks = 0; cyc = 0; quad = 0; dn = 0;
      void'($urandom(65));
      tick(20); rst_n = 1; start_run = 1; tick(1); start_run = 0; tick(3);
      check({31'h0, en}, 32'h1);
      lo = {4'($urandom % 10), 4'($urandom % 10), 8'h00};
      op(`HSC_FN_LOAD_PV, {16'h0, lo});
      check({phi, plo}, {16'h0, lo});
      entry(3'h0, lo | 16'h0003, 16'h0101);
      entry(3'h1, lo | 16'h0006, 16'h0102);
      tcount = 4'h2; tbl_set = 1; tbl_start = 1; tick(1);
      tbl_set = 0; tbl_start = 0; tick(2);
      check({31'h0, cmp}, 32'h1);
      exp_q.push_back(32'h0101); exp_q.push_back(32'h0102);
      half = 3'h4; pulses(8'd6);
      check({phi, plo}, {16'h0, lo | 16'h0006});
      op(`HSC_FN_LOAD_PV, 32'h00065530);
      half = 3'h2; pulses(8'd6);
      check({phi, plo}, `HSC_PV_OVERFLOW);
      check({31'h0, ovf}, 32'h1);
      exp_q.push_back(32'hFFFF); op(`HSC_FN_LOAD_PV, 32'h00000100);
      exp_q.push_back(32'hFFFF); op(`HSC_FN_START_CMP, 32'h0);
      check({phi, plo}, `HSC_PV_OVERFLOW);
      soft_reset = 1; tick(10); soft_reset = 0; tick(6);
      check({phi, plo}, 32'h0);
      check({31'h0, ovf}, 32'h0);
      op(`HSC_FN_STOP_CMP, 32'h0);
      check(32'(exp_q.size()), 32'h0);
      // up/down mode with a two-phase encoder, negative loads
      setup = `HSC_SETUP_UPDN_SW; start_run = 1; tick(1);
      start_run = 0; quad = 1; tick(3);
      op(`HSC_FN_LOAD_PV, 32'hF0000002);
      check({phi, plo}, 32'hF0000002);
      pulses(8'd4);
      check({phi, plo}, 32'h00000002);
      op(`HSC_FN_LOAD_PV, 32'hF0032765);
      dn = 1; pulses(8'd3);
      check({phi, plo}, `HSC_PV_UNDERFLOW);
      check({31'h0, ovf}, 32'h1);
      stop_test();
   end
endmodule
`default_nettype wire
